// ### shared/dfr_pkg.sv
// Package of constants and types for the drive fault reaction logic.
package dfr_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LEVEL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_CAUSE = 4'h5;
    // Number of fault events handled.
    localparam int unsigned NUM_EVT = 5;
    // Event bit positions.
    localparam int unsigned EVT_DATA = 0;
    localparam int unsigned EVT_MTEMP = 1;
    localparam int unsigned EVT_BRES = 2;
    localparam int unsigned EVT_EXT1 = 3;
    localparam int unsigned EVT_I2T = 4;
    // Severity level encoding.
    localparam logic [1:0] LVL_INACTIVE = 2'h0;
    localparam logic [1:0] LVL_MESSAGE = 2'h1;
    localparam logic [1:0] LVL_WARNING = 2'h2;
    localparam logic [1:0] LVL_FAULT = 2'h3;
    // Reaction selections.
    localparam logic QS_SEL_OFF = 1'h0;
    localparam logic [2:0] FR_OPT_COAST = 3'h0;
    localparam logic [2:0] FR_OPT_QSTOP = 3'h2;
    // Stored data cause code limits.
    localparam logic [5:0] CAUSE_DATA_MIN = 6'h01;
    localparam logic [5:0] CAUSE_DATA_MAX = 6'h08;
    localparam logic [5:0] CAUSE_MEM_DEFECT = 6'h30;
    // Control register field positions.
    localparam int unsigned CTRL_QS_BIT = 0;
    localparam int unsigned CTRL_STD_BIT = 1;
    localparam int unsigned CTRL_OPT_LSB = 2;
    localparam int unsigned CTRL_ACK_BIT = 5;
    // Level register field positions.
    localparam int unsigned LVL_MT_LSB = 0;
    localparam int unsigned LVL_I2T_LSB = 2;
    // Reset value of the level register: both levels at fault.
    localparam logic [3:0] LEVEL_RST = 4'hf;
    // Reaction sequencer states.
    typedef enum logic [2:0] {
        DFR_RUN,
        DFR_QSTOP,
        DFR_PWR_OFF,
        DFR_FAULT
    } dfr_state_t;
    // Device state indicator values.
    localparam logic [2:0] DEV_SW_ON_DISABLED = 3'h0;
    localparam logic [2:0] DEV_READY = 3'h1;
    localparam logic [2:0] DEV_SWITCHED_ON = 3'h2;
endpackage

// ### hdl/dfr_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module dfr_sync (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic async_i,
    output logic sync_o
);
    // Synchroniser stages; the first is read only by the second.
    logic s1_q, s2_q, s3_q;
    // Filtered level, changes when stages two and three agree.
    logic out_q, out_d;

    // Accept a new level once the last two stages agree.
    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    // Register the chain and the filtered level.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_o = out_q;
endmodule
`default_nettype wire

// ### hdl/dfr_core.sv
// Drive fault reaction logic: latches events, sequences power stage and brake.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module dfr_core (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic data_invalid_i,
    input wire logic [5:0] data_cause_i,
    input wire logic [1:0] affected_memory_indicator_i,
    input wire logic motor_temp_hot_i,
    input wire logic brake_res_hot_i,
    input wire logic ext_fault1_i,
    input wire logic motor_i2t_hot_i,
    input wire logic quick_stop_done_i,
    input wire logic safety_brake_release_i,
    input wire logic brake_release_override_source_i,
    input wire logic [2:0] device_state_indicator_i,
    output logic power_enable_o,
    output logic brake_release_o,
    output logic quick_stop_req_o,
    output logic warning_o,
    output logic message_o,
    output logic irq_o
);
    import dfr_pkg::*;

    // Synchronised event, quickstop done, safety release and override pins.
    logic [NUM_EVT-1:0] evt_sync;
    logic qs_done_s, safety_rel_s, ovr_s;
    // Synchronised event, quickstop done, safety release and override inputs, one filter each.
    logic [NUM_EVT+2:0] raw_in, syn_out;
    assign raw_in = {brake_release_override_source_i, safety_brake_release_i, quick_stop_done_i,
                     motor_i2t_hot_i, ext_fault1_i, brake_res_hot_i, motor_temp_hot_i, data_invalid_i};
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT + 3; gi++) begin : g_sync
            dfr_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .rstn_i(rstn_i),
                .async_i(raw_in[gi]),
                .sync_o(syn_out[gi])
            );
        end
    endgenerate
    assign evt_sync = syn_out[NUM_EVT-1:0];
    assign qs_done_s = syn_out[NUM_EVT];
    assign safety_rel_s = syn_out[NUM_EVT+1];
    assign ovr_s = syn_out[NUM_EVT+2];

    // Software registers.
    logic [5:0] ctrl_q, ctrl_d;
    logic [3:0] level_q, level_d;
    logic [NUM_EVT-1:0] irq_stat_q, irq_stat_d;
    logic [NUM_EVT-1:0] irq_mask_q, irq_mask_d;
    logic [31:0] rdata_q, rdata_d;
    // Latched faults, causes and sequencer state.
    logic [NUM_EVT-1:0] fault_q, fault_d;
    logic [5:0] cause_q, cause_d;
    logic [1:0] mem_q, mem_d;
    logic no_ack_q, no_ack_d;
    dfr_state_t state_q, state_d;
    logic power_q, power_d;
    logic brake_rel_q, brake_rel_d;
    logic ovr_prev_q, ovr_prev_d;
    logic warn_q, warn_d, msg_q, msg_d;

    // Decoded configuration.
    logic qs_sel, std_profile, ack_req, use_qstop, idle_state, ovr_edge;
    logic [2:0] fr_opt;
    logic [1:0] mt_level, i2t_level;
    logic [NUM_EVT-1:0] evt_fault, evt_new;
    logic data_only;

    always_comb begin
        qs_sel = ctrl_q[CTRL_QS_BIT];
        std_profile = ctrl_q[CTRL_STD_BIT];
        fr_opt = ctrl_q[CTRL_OPT_LSB +: 3];
        ack_req = reg_wr_i && (reg_addr_i == ADDR_CTRL) && reg_wdata_i[CTRL_ACK_BIT];
        mt_level = level_q[LVL_MT_LSB +: 2];
        i2t_level = level_q[LVL_I2T_LSB +: 2];
        // Reaction choice: quickstop by select 1 outside the standard profile, or option 2 under it.
        use_qstop = std_profile ? (fr_opt == FR_OPT_QSTOP) : (qs_sel != QS_SEL_OFF);
        idle_state = (device_state_indicator_i == DEV_SW_ON_DISABLED) ||
                     (device_state_indicator_i == DEV_READY) ||
                     (device_state_indicator_i == DEV_SWITCHED_ON);
        ovr_edge = (ovr_s != ovr_prev_q) && idle_state;
        // Which active events count as faults at their configured level.
        evt_fault[EVT_DATA] = evt_sync[EVT_DATA];
        evt_fault[EVT_MTEMP] = evt_sync[EVT_MTEMP] && (mt_level == LVL_FAULT);
        evt_fault[EVT_BRES] = evt_sync[EVT_BRES];
        evt_fault[EVT_EXT1] = evt_sync[EVT_EXT1];
        evt_fault[EVT_I2T] = evt_sync[EVT_I2T] && (i2t_level == LVL_FAULT);
        evt_new = evt_fault & ~fault_q;
        data_only = fault_q[EVT_DATA] || evt_new[EVT_DATA];
    end

    // Register writes, sticky interrupt bits and read data.
    always_comb begin
        ctrl_d = ctrl_q;
        level_d = level_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        rdata_d = 32'h0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_CTRL: ctrl_d = {1'b0, reg_wdata_i[4:0]};
                ADDR_LEVEL: begin
                    // Motor sensor level keeps warning or fault only.
                    level_d[LVL_MT_LSB +: 2] = reg_wdata_i[LVL_MT_LSB + 1] ?
                        reg_wdata_i[LVL_MT_LSB +: 2] : mt_level;
                    level_d[LVL_I2T_LSB +: 2] = reg_wdata_i[LVL_I2T_LSB +: 2];
                end
                ADDR_IRQ_STAT: irq_stat_d = irq_stat_q & ~reg_wdata_i[NUM_EVT-1:0];
                ADDR_IRQ_MASK: irq_mask_d = reg_wdata_i[NUM_EVT-1:0];
                default: ;
            endcase
        end
        // Setting wins over a clear in the same cycle.
        irq_stat_d = irq_stat_d | evt_new;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_CTRL: rdata_d = {26'h0, ctrl_q};
                ADDR_LEVEL: rdata_d = {28'h0, level_q};
                ADDR_STATUS: rdata_d = {22'h0, no_ack_q, power_q, brake_rel_q, warn_q, msg_q, fault_q};
                ADDR_IRQ_STAT: rdata_d = {27'h0, irq_stat_q};
                ADDR_IRQ_MASK: rdata_d = {27'h0, irq_mask_q};
                ADDR_CAUSE: rdata_d = {24'h0, mem_q, cause_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Fault latching, acknowledgment and reaction sequencing.
    always_comb begin
        fault_d = fault_q | evt_fault;
        cause_d = cause_q;
        mem_d = mem_q;
        no_ack_d = no_ack_q;
        state_d = state_q;
        power_d = power_q;
        brake_rel_d = brake_rel_q;
        ovr_prev_d = ovr_s;
        warn_d = (evt_sync[EVT_MTEMP] && (mt_level == LVL_WARNING)) ||
                 (evt_sync[EVT_I2T] && (i2t_level == LVL_WARNING));
        msg_d = evt_sync[EVT_I2T] && (i2t_level == LVL_MESSAGE);
        if (evt_new[EVT_DATA]) begin
            cause_d = data_cause_i;
            mem_d = affected_memory_indicator_i;
            // Memory causes block any acknowledgment.
            if (((data_cause_i >= CAUSE_DATA_MIN) && (data_cause_i <= CAUSE_DATA_MAX)) ||
                (data_cause_i == CAUSE_MEM_DEFECT)) begin
                no_ack_d = 1'b1;
            end
        end
        unique case (state_q)
            DFR_RUN: begin
                if (ovr_edge) begin
                    brake_rel_d = 1'b1;
                end
                if (data_only) begin
                    power_d = 1'b0;
                    brake_rel_d = safety_rel_s;
                    state_d = DFR_FAULT;
                end else if (|evt_new) begin
                    if (use_qstop) begin
                        state_d = DFR_QSTOP;
                    end else begin
                        power_d = 1'b0;
                        brake_rel_d = 1'b0;
                        state_d = DFR_FAULT;
                    end
                end else begin
                    power_d = 1'b1;
                end
            end
            DFR_QSTOP: begin
                brake_rel_d = 1'b1;
                if (data_only) begin
                    power_d = 1'b0;
                    brake_rel_d = safety_rel_s;
                    state_d = DFR_FAULT;
                end else if (qs_done_s) begin
                    power_d = 1'b0;
                    state_d = DFR_PWR_OFF;
                end
            end
            DFR_PWR_OFF: begin
                // Brake engages one cycle after the power stage is off.
                brake_rel_d = 1'b0;
                state_d = DFR_FAULT;
            end
            DFR_FAULT: begin
                power_d = 1'b0;
                if (fault_q[EVT_DATA]) begin
                    brake_rel_d = safety_rel_s;
                end else if (ovr_edge) begin
                    brake_rel_d = 1'b1;
                end
                if (ack_req && !no_ack_q && !(|evt_fault)) begin
                    fault_d = '0;
                    cause_d = 6'h00;
                    mem_d = 2'h0;
                    brake_rel_d = 1'b0;
                    state_d = DFR_RUN;
                end
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= 6'h00;
            level_q <= LEVEL_RST;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            rdata_q <= 32'h0;
            fault_q <= '0;
            cause_q <= 6'h00;
            mem_q <= 2'h0;
            no_ack_q <= 1'b0;
            state_q <= DFR_RUN;
            power_q <= 1'b0;
            brake_rel_q <= 1'b0;
            ovr_prev_q <= 1'b0;
            warn_q <= 1'b0;
            msg_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            level_q <= level_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            rdata_q <= rdata_d;
            fault_q <= fault_d;
            cause_q <= cause_d;
            mem_q <= mem_d;
            no_ack_q <= no_ack_d;
            state_q <= state_d;
            power_q <= power_d;
            brake_rel_q <= brake_rel_d;
            ovr_prev_q <= ovr_prev_d;
            warn_q <= warn_d;
            msg_q <= msg_d;
        end
    end

    // Outputs.
    assign reg_rdata_o = rdata_q;
    assign power_enable_o = power_q;
    assign brake_release_o = brake_rel_q;
    assign quick_stop_req_o = (state_q == DFR_QSTOP);
    assign warning_o = warn_q;
    assign message_o = msg_q;
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // Power stays off while a fault is latched in the fault state.
    property p_fault_power_off;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (|fault_q) && (state_q == DFR_FAULT) |=> !power_q;
    endproperty
    a_fault_power_off: assert property (p_fault_power_off) else $error("power on with fault latched");

    // Invalid data never enters the quickstop.
    property p_data_no_qstop;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == DFR_RUN) && evt_new[EVT_DATA] |=> (state_q == DFR_FAULT) && !power_q;
    endproperty
    a_data_no_qstop: assert property (p_data_no_qstop) else $error("invalid data used quickstop");

    // Coasting reaction removes power and brake at once.
    property p_coast;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == DFR_RUN) && (|evt_new) && !use_qstop && !data_only |=> !power_q && !brake_rel_q;
    endproperty
    a_coast: assert property (p_coast) else $error("coast reaction not immediate");

    // Brake released from the second quickstop cycle on.
    property p_qs_brake;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == DFR_QSTOP) && $past(state_q == DFR_QSTOP) |-> brake_rel_q;
    endproperty
    a_qs_brake: assert property (p_qs_brake) else $error("brake engaged in quickstop");

    // Quickstop end: power off, brake one cycle later.
    sequence s_qs_end;
        (state_q == DFR_QSTOP) && qs_done_s && !data_only;
    endsequence
    property p_qs_end;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_qs_end |=> !power_q ##1 !brake_rel_q;
    endproperty
    a_qs_end: assert property (p_qs_end) else $error("quickstop end order wrong");

    // Blocked acknowledgment keeps the fault state.
    property p_no_ack;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == DFR_FAULT) && no_ack_q |=> (state_q == DFR_FAULT);
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("memory fault acknowledged");

    // Quickstop selection leads into the quickstop.
    property p_qs_entry;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == DFR_RUN) && (|evt_new) && use_qstop && !data_only |=> quick_stop_req_o;
    endproperty
    a_qs_entry: assert property (p_qs_entry) else $error("quickstop not entered");

    // Braking resistor event always latches.
    property p_bres;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        evt_sync[EVT_BRES] |=> fault_q[EVT_BRES];
    endproperty
    a_bres: assert property (p_bres) else $error("resistor event not latched");
endmodule
`default_nettype wire

// ### sim/dfr_ramp_model.sv
// Model of the quick stop ramp generator and the outside controller's brake release override.
`timescale 1ns/100ps
`default_nettype none
module dfr_ramp_model
    import dfr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic quick_stop_req_i,
    input wire logic [2:0] device_state_indicator_i,
    input wire logic [7:0] ramp_len_i,
    output logic quick_stop_done_o,
    output logic brake_release_override_source_o
);
    logic [7:0] ramp_cnt_q; // Cycles spent on the current ramp.

    // The override line rests low until the controller toggles it.
    initial begin
        brake_release_override_source_o = 1'b0;
    end

    // The ramp runs while a quick stop is requested and reports done once its length has passed.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ramp_cnt_q <= 8'h00;
            quick_stop_done_o <= 1'b0;
        end else if (!quick_stop_req_i) begin
            // No request: the done flag is withdrawn at once.
            ramp_cnt_q <= 8'h00;
            quick_stop_done_o <= 1'b0;
        end else if (ramp_cnt_q >= ramp_len_i) begin
            quick_stop_done_o <= 1'b1;
        end else begin
            ramp_cnt_q <= ramp_cnt_q + 8'h01;
        end
    end

    // Toggles the override line in the idle drive states, or in any state when asked to probe a refusal.
    task automatic toggle_override(input logic any_state);
        @(posedge clk_sys_i);
        if (any_state || (device_state_indicator_i <= DEV_SWITCHED_ON)) begin
            brake_release_override_source_o <= ~brake_release_override_source_o;
        end
    endtask
endmodule
`default_nettype wire

// ### sim/dfr_core_tb_top.sv
// Self-checking testbench for the drive fault reaction logic.
`timescale 1ns/100ps
`default_nettype none
module dfr_core_tb_top;
    import dfr_pkg::*;
    logic clk_sys_i = 1'b0; // System clock, 50 MHz.
    logic rstn_i = 1'b0; // Active-low reset.
    logic [3:0] reg_addr = 4'h0; // Register index.
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, ctrl_v; // Bus data, last read, control word.
    logic reg_wr = 1'b0, reg_rd = 1'b0; // Bus strobes.
    logic data_invalid = 1'b0, mtemp_hot = 1'b0, bres_hot = 1'b0, ext1_hot = 1'b0, i2t_hot = 1'b0; // Events.
    logic [5:0] data_cause = 6'h00; // Stored data cause code.
    logic [1:0] mem_ind = 2'h0; // Affected memory.
    logic safety_rel = 1'b0; // Brake release wanted by the safety module.
    logic [2:0] dev_state = DEV_SW_ON_DISABLED; // Drive state.
    logic [7:0] ramp_len = 8'h04; // Ramp length for the model.
    logic qs_done, override_src, power_en, brake_rel, qs_req, warning, message, irq; // Observed lines.
    logic [31:0] lfsr = 32'h80ad; // Random state.
    logic [31:0] cfg [4]; // Reaction table of control words.
    int n_mismatch = 0, total_checks = 0, cycles = 0; // Counters.

    // Device under test.
    dfr_core uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .data_invalid_i(data_invalid),
        .data_cause_i(data_cause), .affected_memory_indicator_i(mem_ind), .motor_temp_hot_i(mtemp_hot),
        .brake_res_hot_i(bres_hot), .ext_fault1_i(ext1_hot), .motor_i2t_hot_i(i2t_hot),
        .quick_stop_done_i(qs_done), .safety_brake_release_i(safety_rel),
        .brake_release_override_source_i(override_src), .device_state_indicator_i(dev_state),
        .power_enable_o(power_en), .brake_release_o(brake_rel), .quick_stop_req_o(qs_req),
        .warning_o(warning), .message_o(message), .irq_o(irq)
    );

    // Far side: ramp generator and outside controller.
    dfr_ramp_model partner (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .quick_stop_req_i(qs_req),
        .device_state_indicator_i(dev_state), .ramp_len_i(ramp_len),
        .quick_stop_done_o(qs_done), .brake_release_override_source_o(override_src)
    );

    // Clock generator.
    always #10 clk_sys_i = ~clk_sys_i;

    // Cuts a hung run short.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Steps the random generator.
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Builds a control word from selection, profile bit and option code.
    function automatic logic [31:0] ctrl(input logic qs, input logic std, input logic [2:0] opt);
        return (32'(qs) << CTRL_QS_BIT) | (32'(std) << CTRL_STD_BIT) | (32'(opt) << CTRL_OPT_LSB);
    endfunction

    // Selects a watched output: 0 power, 1 brake, else quick stop request.
    function automatic logic pick(input int s);
        return s == 0 ? power_en : (s == 1 ? brake_rel : qs_req);
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Lets some edges pass, then steps off the edge so outputs are settled.
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // One-cycle register write.
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle register read; the data are taken in the following cycle.
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // Waits a bounded time for an output to reach a level, then compares it.
    task automatic wait_out(input int s, input logic v);
        for (int i = 0; i < 60 && pick(s) !== v; i++) begin
            idle(1);
        end
        check(32'(pick(s)), 32'(v));
    endtask

    // Drives one event: 0 motor sensor, 1 braking resistor, 2 motor i2t, 3 external fault.
    task automatic set_evt(input int k, input logic v);
        @(posedge clk_sys_i);
        if (k == 0) mtemp_hot <= v;
        else if (k == 1) bres_hot <= v;
        else if (k == 2) i2t_hot <= v;
        else ext1_hot <= v;
    endtask

    // Lets a released event settle through the filter, then acknowledges.
    task automatic ack_clear();
        idle(8);
        reg_write(ADDR_CTRL, ctrl_v | (32'h1 << CTRL_ACK_BIT));
        idle(6);
    endtask

    // Holds reset for ten cycles, checking that outputs stay quiet.
    task automatic do_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        idle(9);
        check(32'({power_en, brake_rel, qs_req, irq}), 32'h0);
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        cfg = '{ctrl(1'b1, 1'b0, lfsr[2:0]), ctrl(1'b0, 1'b1, FR_OPT_QSTOP), ctrl(1'b1, 1'b1, FR_OPT_COAST),
                ctrl(1'b1, 1'b0, 3'h7)};
        do_reset();
        wait_out(0, 1'b1);
        reg_read(ADDR_LEVEL);
        check(rd_val, {28'h0, LEVEL_RST});
        reg_read(4'hb);
        check(rd_val, 32'h0);
        reg_write(ADDR_IRQ_MASK, 32'h1f);
        // Coasting external fault; the acknowledge is refused while the source stays active.
        ctrl_v = ctrl(QS_SEL_OFF, 1'b0, 3'h5);
        reg_write(ADDR_CTRL, ctrl_v);
        set_evt(3, 1'b1);
        wait_out(0, 1'b0);
        check(32'({brake_rel, qs_req, irq}), 32'h1);
        reg_read(ADDR_STATUS);
        check(rd_val[4:0], 5'h1 << EVT_EXT1);
        ack_clear();
        check(32'(power_en), 32'h0);
        reg_write(ADDR_IRQ_MASK, 32'h0);
        check(32'(irq), 32'h0);
        reg_write(ADDR_IRQ_MASK, 32'h1f);
        set_evt(3, 1'b0);
        ack_clear();
        check(32'(power_en), 32'h1);
        reg_write(ADDR_IRQ_STAT, 32'h1f);
        check(32'(irq), 32'h0);
        // Override edges outside the idle states leave the brake engaged; an even count keeps the pin low.
        @(posedge clk_sys_i);
        dev_state <= 3'h4;
        repeat (2) begin
            partner.toggle_override(1'b1);
            idle(6);
            check(32'(brake_rel), 32'h0);
        end
        // Reaction table: entry 2 coasts by option code, the others ramp down first.
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_sys_i);
            ramp_len <= lfsr[7:0] & 8'h1f;
            dev_state <= 3'(lfsr[9:8] % 2'h3);
            partner.toggle_override(1'b0);
            wait_out(1, 1'b1);
            ctrl_v = cfg[i];
            reg_write(ADDR_CTRL, ctrl_v);
            set_evt(i, 1'b1);
            if (i != 2) begin
                wait_out(2, 1'b1);
                check(32'({power_en, brake_rel}), 32'h3);
                wait_out(0, 1'b0);
                check(32'(brake_rel), 32'h1);
                idle(1);
                check(32'(brake_rel), 32'h0);
            end else begin
                wait_out(0, 1'b0);
                check(32'({brake_rel, qs_req}), 32'h0);
            end
            set_evt(i, 1'b0);
            ack_clear();
            check(32'(power_en), 32'h1);
        end
        // Motor i2t levels below fault keep the power unit on.
        for (int lv = 0; lv < 3; lv++) begin
            reg_write(ADDR_LEVEL, (32'(lv) << LVL_I2T_LSB) | 32'h3);
            set_evt(2, 1'b1);
            idle(8);
            check(32'(power_en), 32'h1);
            check(32'(lv == 1 ? message : warning), 32'(lv != 0));
            set_evt(2, 1'b0);
            idle(8);
        end
        // A motor sensor level of 1 is not taken; level 2 only warns.
        reg_write(ADDR_LEVEL, 32'he);
        reg_write(ADDR_LEVEL, 32'hd);
        reg_read(ADDR_LEVEL);
        check(rd_val, 32'he);
        set_evt(0, 1'b1);
        idle(8);
        check(32'({power_en, warning}), 32'h3);
        set_evt(0, 1'b0);
        // Stored data faults: a random cause, then defective memory; only reset clears them.
        for (int j = 0; j < 2; j++) begin
            lfsr = lfsr_next(lfsr);
            ctrl_v = ctrl(1'b1, 1'b0, FR_OPT_QSTOP);
            reg_write(ADDR_CTRL, ctrl_v);
            @(posedge clk_sys_i);
            data_cause <= j == 0 ? 6'(lfsr[2:0]) + 6'h1 : CAUSE_MEM_DEFECT;
            mem_ind <= lfsr[5:4];
            safety_rel <= 1'b1;
            data_invalid <= 1'b1;
            wait_out(0, 1'b0);
            check(32'(qs_req), 32'h0);
            wait_out(1, 1'b1);
            @(posedge clk_sys_i);
            safety_rel <= 1'b0;
            wait_out(1, 1'b0);
            reg_read(ADDR_CAUSE);
            check(rd_val[7:0], {mem_ind, data_cause});
            @(posedge clk_sys_i);
            data_invalid <= 1'b0;
            ack_clear();
            reg_read(ADDR_STATUS);
            check(32'({rd_val[9], rd_val[8], rd_val[EVT_DATA]}), 32'h5);
            do_reset();
            wait_out(0, 1'b1);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
